/* shared/status_pkg.sv */
// status_pkg: constants, command codes and helpers shared by the status register bank.
// assumes a single 20 MHz clock and a command parser that decodes text commands to cmd_t.
package status_pkg;

    // ----------------------------------------
    // widths and limits
    // ----------------------------------------
    localparam int          REG_W      = 8;
    localparam int          VALUE_W    = 16;
    localparam logic [15:0] VALUE_MAX  = 16'h00FF;
    localparam logic [7:0]  OPC_REPLY  = 8'h01;
    localparam logic [7:0]  MASK_RESET = 8'h00;
    localparam logic [7:0]  EV_RESET   = 8'h80;

    // ----------------------------------------
    // status byte bit positions
    // ----------------------------------------
    localparam int SB_ERRQ   = 2;
    localparam int SB_QUES   = 3;
    localparam int SB_MAV    = 4;
    localparam int SB_ESB    = 5;
    localparam int SB_MASTER = 6;
    localparam logic [7:0] SB_USED      = 8'h7C;
    localparam logic [7:0] SB_NO_MASTER = 8'hBF;

    // ----------------------------------------
    // standard event bit positions
    // ----------------------------------------
    localparam int EV_OPC = 0;
    localparam int EV_QYE = 2;
    localparam int EV_DDE = 3;
    localparam int EV_EXE = 4;
    localparam int EV_CME = 5;
    localparam int EV_PON = 7;
    localparam logic [7:0] EV_USED = 8'hBD;

    // ----------------------------------------
    // commands and states
    // ----------------------------------------
    typedef enum logic [3:0] {
        CMD_NONE   = 4'h0,
        CMD_SRE_WR = 4'h1,
        CMD_SRE_RD = 4'h2,
        CMD_SB_RD  = 4'h3,
        CMD_ESE_WR = 4'h4,
        CMD_ESE_RD = 4'h5,
        CMD_EV_RD  = 4'h6,
        CMD_CLS    = 4'h7,
        CMD_OPC    = 4'h8,
        CMD_OPC_RD = 4'h9
    } cmd_t;

    typedef enum logic [0:0] {
        OPC_IDLE = 1'b0,
        OPC_WAIT = 1'b1
    } opc_state_t;

    // values above the mask range saturate rather than wrap
    function automatic logic [7:0] clamp8(input logic [15:0] v);
        clamp8 = (v > VALUE_MAX) ? VALUE_MAX[7:0] : v[7:0];
    endfunction : clamp8

endpackage : status_pkg

/* hdl/event_latch.sv */
// event_latch: sticky event flags with a clear strobe; a set in the clear cycle survives.
// assumes set pulses and clear are synchronous to clk.
`timescale 1ns/1ns
module event_latch #(
    parameter int         WIDTH  = 8,
    parameter logic [7:0] USED   = 8'hFF,
    parameter logic [7:0] RST_VL = 8'h00
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] set,
    input  wire logic             clear,
    output logic      [WIDTH-1:0] flags
);
    import status_pkg::*;

    initial begin
        if (WIDTH != REG_W) $error("event_latch supports only 8-bit registers");
    end

    logic [WIDTH-1:0] flags_reg;
    wire  [WIDTH-1:0] flags_next = ((clear ? '0 : flags_reg) | set) & USED;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) flags_reg <= RST_VL & USED;
        else     flags_reg <= flags_next;
    end

    assign flags = flags_reg;

endmodule : event_latch

/* hdl/opc_tracker.sv */
// opc_tracker: waits after a start strobe until no operation is pending, then pulses done.
// assumes ops_pending is a synchronous level from the operation sequencer.
`timescale 1ns/1ns
module opc_tracker (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic start,
    input  wire logic ops_pending,
    output logic      busy,
    output logic      done
);
    import status_pkg::*;

    opc_state_t state_reg;
    opc_state_t state_next;
    logic       done_reg;
    wire        finish = (state_reg == OPC_WAIT) && !ops_pending;

    always_comb begin
        case (state_reg)
            OPC_IDLE: state_next = start ? OPC_WAIT : OPC_IDLE;
            OPC_WAIT: state_next = ops_pending ? OPC_WAIT : OPC_IDLE;
            default:  state_next = OPC_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= OPC_IDLE;
            done_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            done_reg  <= finish;
        end
    end

    assign busy = (state_reg == OPC_WAIT);
    assign done = done_reg;

endmodule : opc_tracker

/* hdl/status_reporting_registers.sv */
// status_reporting_registers: status byte, service request mask, standard event flags and mask,
// with the common status commands and operation-complete signalling.
// assumes a parser that hands over one decoded command at a time and an output queue
// that takes reply_data whenever reply_valid is high.
//
// Summary of operation
// - service request mask write stores the value as 8-bit mask, range 0..255
// - service request mask query returns the current mask, 0..255
// - status byte query returns the byte; master summary flag is not cleared
// - standard event mask write loads the value clamped to 0..255
// - standard event mask query returns the stored 8-bit mask, unused positions 1 and 6 included
// - standard event query returns the 8-bit flags, at most 255
// - clear-status zeroes the event flags and pulses clear_groups; level summary bits follow their inputs
// - operation-complete command waits for pending operations, then sets flag bit 0
// - operation-complete query queues 1 once pending operations have finished
// - status byte: 2 errors, 3 questionable, 4 message, 5 event, 6 master
// - event flags: 0 opc, 2 query, 3 device, 4 exec, 5 command, 7 power-on
// - event flags stay latched; cleared by query or clear-status only
// - masks gate summaries; reading or clear-status leaves masks alone
`timescale 1ns/1ns
module status_reporting_registers (
    input  wire logic                           clk,
    input  wire logic                           rst,
    input  wire logic                           cmd_valid,
    input  wire status_pkg::cmd_t               cmd_code,
    input  wire logic [status_pkg::VALUE_W-1:0] cmd_value,
    input  wire logic                           ops_pending,
    input  wire logic                           error_queue_nonempty,
    input  wire logic                           questionable_summary,
    input  wire logic                           message_available,
    input  wire logic                           query_error,
    input  wire logic                           device_error,
    input  wire logic                           execution_error,
    input  wire logic                           command_error,
    output logic                                cmd_ready,
    output logic                                reply_valid,
    output logic [status_pkg::REG_W-1:0]        reply_data,
    output logic [status_pkg::REG_W-1:0]        status_byte,
    output logic [status_pkg::REG_W-1:0]        event_flags,
    output logic                                clear_groups
);
    import status_pkg::*;

    // ----------------------------------------
    // command decode
    // ----------------------------------------
    wire take       = cmd_valid && cmd_ready;
    wire take_sre_w = take && (cmd_code == CMD_SRE_WR);
    wire take_sre_r = take && (cmd_code == CMD_SRE_RD);
    wire take_sb_r  = take && (cmd_code == CMD_SB_RD);
    wire take_ese_w = take && (cmd_code == CMD_ESE_WR);
    wire take_ese_r = take && (cmd_code == CMD_ESE_RD);
    wire take_ev_r  = take && (cmd_code == CMD_EV_RD);
    wire take_cls   = take && (cmd_code == CMD_CLS);
    wire take_opc   = take && (cmd_code == CMD_OPC);
    wire take_opc_r = take && (cmd_code == CMD_OPC_RD);

    logic [7:0] service_request_mask_reg;
    logic [7:0] standard_event_mask_reg;
    logic [7:0] status_byte_reg;
    logic [7:0] reply_data_reg;
    logic       reply_valid_reg;
    logic       cmd_ready_reg;
    logic       clear_groups_reg;
    logic [7:0] ev_flags;
    logic       opc_busy;
    logic       opc_done;
    logic       opcq_busy;
    logic       opcq_done;

    // ----------------------------------------
    // operation-complete waits
    // ----------------------------------------
    opc_tracker u_opc_cmd (
        .clk         (clk),
        .rst         (rst),
        .start       (take_opc),
        .ops_pending (ops_pending),
        .busy        (opc_busy),
        .done        (opc_done)
    );

    opc_tracker u_opc_query (
        .clk         (clk),
        .rst         (rst),
        .start       (take_opc_r),
        .ops_pending (ops_pending),
        .busy        (opcq_busy),
        .done        (opcq_done)
    );

    // ----------------------------------------
    // standard event flags
    // ----------------------------------------
    logic [7:0] ev_set;
    always_comb begin
        ev_set         = 8'h00;
        ev_set[EV_OPC] = opc_done;
        ev_set[EV_QYE] = query_error;
        ev_set[EV_DDE] = device_error;
        ev_set[EV_EXE] = execution_error;
        ev_set[EV_CME] = command_error;
    end

    // power-on bit comes only from the reset value; a query or clear-status clears it until the next reset
    wire ev_clear = take_ev_r || take_cls;

    event_latch #(
        .WIDTH  (REG_W),
        .USED   (EV_USED),
        .RST_VL (EV_RESET)
    ) u_ev (
        .clk   (clk),
        .rst   (rst),
        .set   (ev_set),
        .clear (ev_clear),
        .flags (ev_flags)
    );

    // ----------------------------------------
    // summaries
    // ----------------------------------------
    wire        event_summary = |(ev_flags & standard_event_mask_reg);
    logic [7:0] sb_core;
    always_comb begin
        sb_core          = 8'h00;
        sb_core[SB_ERRQ] = error_queue_nonempty;
        sb_core[SB_QUES] = questionable_summary;
        sb_core[SB_MAV]  = message_available;
        sb_core[SB_ESB]  = event_summary;
    end
    // reserved positions of sb_core are zero, so ANDing them with the mask adds nothing
    wire        master_summary_flag = |(sb_core & service_request_mask_reg & SB_NO_MASTER);
    wire  [7:0] sb_next = (sb_core & SB_USED) | (8'(master_summary_flag) << SB_MASTER);

    // ----------------------------------------
    // reply selection
    // ----------------------------------------
    wire        reply_next = take_sre_r || take_sb_r || take_ese_r || take_ev_r || opcq_done;
    wire  [7:0] reply_sel =
        take_sre_r ? service_request_mask_reg :
        take_sb_r  ? status_byte_reg :
        take_ese_r ? standard_event_mask_reg :
        take_ev_r  ? ev_flags :
        opcq_done  ? OPC_REPLY : 8'h00;
    // holding the parser off until the query answer is out keeps replies in command order
    wire        cmd_ready_next = !(take_opc_r || opcq_busy || opcq_done);

    wire  [7:0] sre_next = take_sre_w ? clamp8(cmd_value) : service_request_mask_reg;
    wire  [7:0] ese_next = take_ese_w ? clamp8(cmd_value) : standard_event_mask_reg;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            service_request_mask_reg <= MASK_RESET;
            standard_event_mask_reg  <= MASK_RESET;
            status_byte_reg          <= 8'h00;
            reply_data_reg           <= 8'h00;
            reply_valid_reg          <= 1'b0;
            cmd_ready_reg            <= 1'b1;
            clear_groups_reg         <= 1'b0;
        end else begin
            service_request_mask_reg <= sre_next;
            standard_event_mask_reg  <= ese_next;
            status_byte_reg          <= sb_next;
            reply_data_reg           <= reply_next ? reply_sel : reply_data_reg;
            reply_valid_reg          <= reply_next;
            cmd_ready_reg            <= cmd_ready_next;
            clear_groups_reg         <= take_cls;
        end
    end

    assign cmd_ready    = cmd_ready_reg;
    assign reply_valid  = reply_valid_reg;
    assign reply_data   = reply_data_reg;
    assign status_byte  = status_byte_reg;
    assign event_flags  = ev_flags;
    assign clear_groups = clear_groups_reg;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_opc_wait;
        opc_busy && !ops_pending;
    endsequence

    // the event latch registers done, so the flag follows one cycle later
    sequence s_opc_set;
        opc_done ##1 ev_flags[EV_OPC];
    endsequence

    // the parser stays held off through the reply cycle so replies keep command order
    sequence s_opcq_reply;
        reply_valid && reply_data == OPC_REPLY && !cmd_ready ##1 cmd_ready;
    endsequence

    // ----------------------------------------
    // assertions: commands and summaries
    // ----------------------------------------

    a_sre_write_store: assert property (take_sre_w |=> service_request_mask_reg == clamp8($past(cmd_value)))
        else $error("service request mask not loaded");

    a_sre_query_reply: assert property (take_sre_r |=> reply_valid && reply_data == $past(service_request_mask_reg)
        && service_request_mask_reg == $past(service_request_mask_reg))
        else $error("service request mask query wrong");

    a_sb_query_reply: assert property (take_sb_r |=> reply_valid && reply_data == $past(status_byte_reg)
        && status_byte_reg[SB_MASTER] == $past(master_summary_flag))
        else $error("status byte query wrong");

    a_ese_write_store: assert property (take_ese_w |=> standard_event_mask_reg == clamp8($past(cmd_value)))
        else $error("event mask not loaded");

    a_ese_query_reply: assert property (take_ese_r |=> reply_valid && reply_data == $past(standard_event_mask_reg))
        else $error("event mask query wrong");

    a_ev_query_clear: assert property (take_ev_r |=> reply_data == $past(ev_flags)
        && ev_flags == ($past(ev_set) & EV_USED))
        else $error("event query did not return and clear");

    a_cls_clears_all: assert property (take_cls |=> clear_groups && ev_flags == ($past(ev_set) & EV_USED)
        && standard_event_mask_reg == $past(standard_event_mask_reg))
        else $error("clear-status wrong");

    a_opc_sets_flag: assert property (s_opc_wait |=> s_opc_set)
        else $error("operation complete flag not set");

    a_opc_not_early: assert property ($rose(ev_flags[EV_OPC])
        |-> $past(opc_busy, 2) && !$past(ops_pending, 2))
        else $error("operation complete flag set early");

    a_opcq_reply_one: assert property (opcq_busy && !ops_pending |=> ##1 reply_valid && reply_data == OPC_REPLY)
        else $error("operation complete query reply wrong");

    a_reserved_zero: assert property (!status_byte_reg[0] && !status_byte_reg[1] && !status_byte_reg[7]
        && !ev_flags[1] && !ev_flags[6])
        else $error("reserved status bit set");

    a_flags_latched: assert property (!ev_clear |=> (ev_flags & $past(ev_flags)) == $past(ev_flags))
        else $error("event flag dropped without clear");

    a_mss_summary: assert property (status_byte_reg[SB_MASTER] == |($past(sb_core) & $past(service_request_mask_reg)))
        else $error("master summary wrong");

    a_esb_summary: assert property (status_byte_reg[SB_ESB]
        == |($past(ev_flags) & $past(standard_event_mask_reg)))
        else $error("event summary wrong");

    a_masks_kept_cls: assert property (take_cls |=> service_request_mask_reg == $past(service_request_mask_reg))
        else $error("clear-status touched a mask");

    // ----------------------------------------
    // assertions: operation-complete handshake
    // ----------------------------------------

    a_opcq_ready_low: assert property (take_opc_r |=> !cmd_ready && opcq_busy)
        else $error("parser not held off during wait");

    a_opcq_ready_back: assert property (opcq_done |=> s_opcq_reply)
        else $error("completion reply or release wrong");

    // ----------------------------------------
    // assertions: event flags
    // ----------------------------------------

    a_pon_only_reset: assert property (!ev_flags[EV_PON] |=> !ev_flags[EV_PON])
        else $error("power-on flag set outside reset");

    // a set arriving with a clear must survive it
    a_err_bits_latch: assert property (|ev_set
        |=> (ev_flags & $past(ev_set)) == $past(ev_set))
        else $error("event bit not latched");

    a_groups_cause: assert property (clear_groups |-> $past(take_cls))
        else $error("group clear without command");

    // ----------------------------------------
    // assertions: masks and status byte
    // ----------------------------------------

    a_sre_mask_hold: assert property (!take_sre_w |=> $stable(service_request_mask_reg))
        else $error("service request mask changed");

    a_ese_mask_hold: assert property (!take_ese_w |=> $stable(standard_event_mask_reg))
        else $error("event mask changed");

    a_ese_saturate: assert property (take_ese_w && cmd_value > VALUE_MAX
        |=> standard_event_mask_reg == VALUE_MAX[7:0])
        else $error("event mask not saturated");

    // level inputs pass through one register stage before they show
    a_sb_level_bits: assert property (!$past(rst) |-> status_byte_reg[SB_ERRQ] == $past(error_queue_nonempty)
        && status_byte_reg[SB_QUES] == $past(questionable_summary)
        && status_byte_reg[SB_MAV] == $past(message_available))
        else $error("status byte level bits wrong");

    a_reply_data_hold: assert property (!reply_valid |-> $stable(reply_data))
        else $error("reply data moved without reply");

endmodule : status_reporting_registers

/* tb/host_model.sv */
// host_model: remote host that hands decoded status commands to the bank and collects replies.
// assumes a single clock; requests change just after a rising edge and hold until taken.
`timescale 1ns/1ns
module host_model (
    input  wire logic                           clk,
    input  wire logic                           cmd_ready,
    input  wire logic                           reply_valid,
    input  wire logic [status_pkg::REG_W-1:0]   reply_data,
    output status_pkg::cmd_t                    cmd_code,
    output logic                                cmd_valid,
    output logic [status_pkg::VALUE_W-1:0]      cmd_value
);
    import status_pkg::*;

    initial begin
        cmd_valid = 1'b0;
        cmd_code  = CMD_NONE;
        cmd_value = 16'h0000;
    end

    // ----------------------------------------
    // request: held until cmd_ready is seen high at an edge
    // ----------------------------------------
    task automatic issue(input cmd_t code, input logic [15:0] value, output bit ok);
        ok = 1'b0;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_code  <= code;
        cmd_value <= value;
        for (int n = 0; n < 40 && !ok; n++) begin
            @(posedge clk);
            ok = (cmd_ready === 1'b1);
        end
        cmd_valid <= 1'b0;
        cmd_code  <= CMD_NONE;
        // released value is inverted so a stale argument is never mistaken for a fresh one
        cmd_value <= ~value;
    endtask : issue

    // ----------------------------------------
    // reply: the pulse stands for one cycle only, so every edge is looked at
    // ----------------------------------------
    task automatic await_reply(input int limit, output logic [7:0] data, output bit ok);
        ok   = 1'b0;
        data = 8'h00;
        for (int n = 0; n < limit && !ok; n++) begin
            @(posedge clk);
            if (reply_valid === 1'b1) begin
                ok   = 1'b1;
                data = reply_data;
            end
        end
    endtask : await_reply
endmodule : host_model

/* tb/tb.sv */
// tb: self-checking bench for the status register bank; table rows first, then hand-written cases.
// assumes host_model drives the command port and the status package is compiled first.
`timescale 1ns/1ns
`define CHK(got, exp, msg) begin samples_checked++; if ((got) !== (exp)) begin errors++; $display("FAIL %0t %s", $time, msg); end end
module tb;
    import status_pkg::*;

    logic       clk;
    logic       rst;
    logic       cmd_valid;
    cmd_t       cmd_code;
    logic [15:0] cmd_value;
    logic       ops_pending;
    logic [2:0] levels;
    logic [3:0] errs;
    logic       cmd_ready;
    logic       reply_valid;
    logic [7:0] reply_data;
    logic [7:0] status_byte;
    logic [7:0] event_flags;
    logic       clear_groups;
    logic [7:0] data;
    bit         ok;
    bit         got;
    int         errors;
    int         samples_checked;

    // ----------------------------------------
    // rows: {code, argument, expected reply}
    // ----------------------------------------
    localparam logic [27:0] ROWS [0:9] = '{28'h1000700, 28'h2000007, 28'h4004100, 28'h5000041, 28'h4012C00,
                                           28'h50000FF, 28'h6000080, 28'h6000000, 28'h100FF00, 28'h20000FF};

    status_reporting_registers dut_u (
        .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_value(cmd_value),
        .ops_pending(ops_pending), .error_queue_nonempty(levels[0]), .questionable_summary(levels[1]),
        .message_available(levels[2]), .query_error(errs[0]), .device_error(errs[1]),
        .execution_error(errs[2]), .command_error(errs[3]), .cmd_ready(cmd_ready),
        .reply_valid(reply_valid), .reply_data(reply_data), .status_byte(status_byte),
        .event_flags(event_flags), .clear_groups(clear_groups));

    host_model host_u (
        .clk(clk), .cmd_ready(cmd_ready), .reply_valid(reply_valid), .reply_data(reply_data),
        .cmd_code(cmd_code), .cmd_valid(cmd_valid), .cmd_value(cmd_value));

    task automatic print_verdict();
        if (errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict

    task automatic timeout();
        errors++;
        $display("FAIL %0t no response in time", $time);
        print_verdict();
    endtask : timeout

    task automatic send(input cmd_t code, input logic [15:0] value);
        bit taken;
        host_u.issue(code, value, taken);
        if (!taken) timeout();
    endtask : send

    task automatic query(input cmd_t code, input logic [7:0] exp);
        logic [7:0] rd;
        bit         seen;
        send(code, 16'h0000);
        host_u.await_reply(20, rd, seen);
        if (!seen) timeout();
        `CHK(rd, exp, "reply value")
    endtask : query

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        rst         = 1'b1;
        ops_pending = 1'b0;
        levels      = 3'h0;
        errs        = 4'h0;
        errors      = 0;
        samples_checked = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK(event_flags, 8'h80, "power-on flags")
        `CHK(status_byte, 8'h00, "status byte after reset")
        for (int i = 0; i < 10; i++) begin
            if (ROWS[i][27:24] inside {4'h2, 4'h5, 4'h6}) begin
                query(cmd_t'(ROWS[i][27:24]), ROWS[i][7:0]);
            end else begin
                send(cmd_t'(ROWS[i][27:24]), ROWS[i][23:8]);
            end
        end
        // ----------------------------------------
        // latched errors and the two summaries
        // ----------------------------------------
        send(CMD_ESE_WR, 16'h003C);
        send(CMD_SRE_WR, 16'h0020);
        @(posedge clk);
        errs <= 4'hF;
        @(posedge clk);
        errs <= 4'h0;
        repeat (4) @(posedge clk);
        `CHK(event_flags, 8'h3C, "error flags not latched")
        `CHK(status_byte, 8'h60, "event and master summary")
        levels <= 3'h7;
        send(CMD_SRE_WR, 16'h0004);
        repeat (4) @(posedge clk);
        `CHK(status_byte, 8'h7C, "status byte levels")
        query(CMD_SB_RD, 8'h7C);
        repeat (2) @(posedge clk);
        `CHK(status_byte[6], 1'b1, "master summary lost on read")
        // ----------------------------------------
        // clear-status keeps masks
        // ----------------------------------------
        levels <= 3'h0;
        repeat (3) @(posedge clk);
        send(CMD_CLS, 16'h0000);
        got = 1'b0;
        for (int n = 0; n < 4; n++) begin
            @(posedge clk);
            got = got | (clear_groups === 1'b1);
        end
        `CHK(got, 1'b1, "group clear pulse")
        `CHK(event_flags, 8'h00, "flags after clear")
        `CHK(status_byte, 8'h00, "status byte after clear")
        query(CMD_ESE_RD, 8'h3C);
        query(CMD_SRE_RD, 8'h04);
        // ----------------------------------------
        // operation complete, command and query
        // ----------------------------------------
        ops_pending <= 1'b1;
        send(CMD_OPC, 16'h0000);
        repeat (6) @(posedge clk);
        `CHK(event_flags[0], 1'b0, "complete flag too early")
        ops_pending <= 1'b0;
        repeat (5) @(posedge clk);
        `CHK(event_flags, 8'h01, "complete flag")
        ops_pending <= 1'b1;
        send(CMD_OPC_RD, 16'h0000);
        host_u.await_reply(8, data, ok);
        `CHK(ok, 1'b0, "reply while pending")
        ops_pending <= 1'b0;
        host_u.await_reply(20, data, ok);
        `CHK(ok, 1'b1, "no completion reply")
        `CHK(data, 8'h01, "completion reply value")
        // ----------------------------------------
        // reset in mid-run
        // ----------------------------------------
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK(event_flags, 8'h80, "flags after second reset")
        query(CMD_SRE_RD, 8'h00);
        print_verdict();
    end
endmodule : tb
